//--- psdl_defs.vh
// Register map, reset values, encodings and timing for the panel logic
`ifndef PSDL_DEFS_VH
`define PSDL_DEFS_VH

// Register byte offsets
`define PSDL_REG_STATUS      8'h00
`define PSDL_REG_SPEED_TH    8'h04
`define PSDL_REG_POS_TH      8'h08
`define PSDL_REG_ROT_TH      8'h0C
`define PSDL_REG_TORQ_LVL    8'h10
`define PSDL_REG_EDIT        8'h14

// Reset values of the threshold registers and the edit value
`define PSDL_RST_SPEED_TH    16'h000A
`define PSDL_RST_POS_TH      32'h0000000A
`define PSDL_RST_ROT_TH      16'h0014
`define PSDL_RST_TORQ_LVL    16'h000A
`define PSDL_RST_EDIT        20'h00000

// Status register fields
`define PSDL_ST_MODE_LSB     0
`define PSDL_ST_CODE_LSB     4
`define PSDL_ST_SEG_LSB      8
`define PSDL_ST_SHOWN_BIT    16
`define PSDL_ST_DIGIT_LSB    17

// Control modes reported by the servo core
`define PSDL_CM_SPEED        2'h0
`define PSDL_CM_POSITION     2'h1
`define PSDL_CM_TORQUE       2'h2

// Operation state codes on the code digits
`define PSDL_SC_INIT_FAIL    4'h0
`define PSDL_SC_SERVO_OFF    4'h1
`define PSDL_SC_READY        4'h2
`define PSDL_SC_RUN          4'h3
`define PSDL_SC_QSTOP        4'h4
`define PSDL_SC_ALARM        4'h5
`define PSDL_SC_SAFE         4'h6
`define PSDL_SC_FWD_PROH     4'h7
`define PSDL_SC_REV_PROH     4'h8
`define PSDL_SC_OVERTRAVEL   4'h9
`define PSDL_SC_ALM_NUM      4'hA

// Timing
`define PSDL_CLK_KHZ         125000
`define PSDL_DEBOUNCE_MS     10
`define PSDL_ALT_MS          500
`define PSDL_DEBOUNCE_CYC    21'h1312D0
`define PSDL_ALT_CYC         26'h3B9ACA0

`endif

//--- psdl_key_debounce.v
// Key synchroniser and debouncer giving one pulse per press
`timescale 1ns/10ps
module psdl_key_debounce #(
    parameter [20:0] DEBOUNCE_CYC = 21'h1312D0
) (
    input  wire clk_i,
    input  wire rst_i,
    input  wire key_n_i,
    output reg  press_o
);

    reg        sync1_q;
    reg        sync2_q;
    reg        stable_q;
    reg [20:0] cnt_q;

    always @(posedge clk_i) begin
        if (rst_i) begin
            sync1_q  <= 1'b0;
            sync2_q  <= 1'b0;
            stable_q <= 1'b0;
            cnt_q    <= 21'h000000;
            press_o  <= 1'b0;
        end else begin
            sync1_q <= ~key_n_i;
            sync2_q <= sync1_q;
            press_o <= 1'b0;
            // Level must hold for the full window before it counts
            if (sync2_q == stable_q) begin
                cnt_q <= 21'h000000;
            end else if (cnt_q >= DEBOUNCE_CYC - 21'h000001) begin
                cnt_q    <= 21'h000000;
                stable_q <= sync2_q;
                press_o  <= sync2_q;
            end else begin
                cnt_q <= cnt_q + 21'h000001;
            end
        end
    end

endmodule

//--- psdl_top.v
// Front-panel key handling, mode selection and status display logic
`timescale 1ns/10ps
`include "psdl_defs.vh"

// Contract
// - Mode key steps status, parameter, utility, monitor modes.
// - Up key increments the value being set.
// - Down key decrements the value being set.
// - Data key shows the value; while editing it shifts digit left.
// - After initialisation ends, status display shows with no key.
// - Two bit-data digits show signal states; three digits show a code.
// - Speed mode segment 1 lit while speed error within threshold.
// - Torque mode segment 1 always lit.
// - Position mode segment 1 lit while position error below threshold.
// - Segment 2 lit while servo off, dark while servo on.
// - Segment 3 lit while control power present.
// - Speed or torque mode segment 4 lit when speed reference high.
// - Position mode segment 4 lit while reference pulses arrive.
// - Speed or torque mode segment 5 lit when torque reference high.
// - Position mode segment 5 lit while deviation clear asserted.
// - Segment 6 lit while main power circuit is normal.
// - Segment 7 lit while motor speed exceeds rotation threshold.
// - Code shows init fail, off, ready, run, quick stop or alarm.
// - Code also shows safe, prohibits, overtravel and alarm number.
// - Data key in alarm state requests alarm clearing; the code does so only in status display mode.
module psdl_top #(
    parameter [20:0] DEBOUNCE_CYC = `PSDL_DEBOUNCE_CYC,
    parameter [25:0] ALT_CYC      = `PSDL_ALT_CYC
) (
    input  wire        clk_i,
    input  wire        rst_i,
    input  wire        wb_cyc_i,
    input  wire        wb_stb_i,
    input  wire        wb_we_i,
    input  wire [7:0]  wb_adr_i,
    input  wire [3:0]  wb_sel_i,
    input  wire [31:0] wb_dat_i,
    output reg  [31:0] wb_dat_o,
    output reg         wb_ack_o,
    input  wire        key_mode_n_i,
    input  wire        key_up_n_i,
    input  wire        key_down_n_i,
    input  wire        key_data_n_i,
    input  wire        init_done_i,
    input  wire [1:0]  ctrl_mode_i,
    input  wire        servo_on_i,
    input  wire        ctrl_power_i,
    input  wire        main_power_ok_i,
    input  wire        ref_pulse_active_i,
    input  wire        dev_clear_i,
    input  wire [15:0] motor_speed_i,
    input  wire [15:0] speed_ref_i,
    input  wire [15:0] torque_ref_i,
    input  wire [31:0] pos_error_i,
    input  wire [3:0]  drive_state_i,
    output reg  [3:0]  panel_mode_o,
    output reg  [6:0]  bit_seg_o,
    output reg  [2:0]  state_code_pad_o,
    output reg  [3:0]  state_code_o,
    output reg  [19:0] edit_value_o,
    output reg  [2:0]  edit_digit_o,
    output reg         value_shown_o,
    output reg         alarm_clear_o
);

    ////////////////////////////////////////////////////////////////////
    // Panel mode states, one-hot
    localparam [4:0] MD_INIT    = 5'h01;
    localparam [4:0] MD_STATUS  = 5'h02;
    localparam [4:0] MD_PARAM   = 5'h04;
    localparam [4:0] MD_UTIL    = 5'h08;
    localparam [4:0] MD_MONITOR = 5'h10;

    reg  [4:0]  mode_q;
    reg  [4:0]  mode_d;
    reg  [15:0] speed_th_q;
    reg  [31:0] pos_th_q;
    reg  [15:0] rot_th_q;
    reg  [15:0] torq_lvl_q;
    reg  [25:0] alt_cnt_q;
    reg         alt_sel_q;
    reg  [6:0]  seg_d;
    reg  [3:0]  code_d;

    wire        press_mode;
    wire        press_up;
    wire        press_down;
    wire        press_data;
    wire        wb_req;
    wire        wb_wr;
    wire        in_alarm;
    wire        edit_mode;
    wire [16:0] speed_err;
    wire        speed_match;
    wire        pos_done;
    wire        rot_seen;
    wire        speed_ref_hi;
    wire        torq_ref_hi;

    ////////////////////////////////////////////////////////////////////
    // Helpers

    function [15:0] abs16;
        input [15:0] v;
        begin
            abs16 = v[15] ? (~v + 16'h0001) : v;
        end
    endfunction

    function [16:0] abs17;
        input [16:0] v;
        begin
            abs17 = v[16] ? (~v + 17'h00001) : v;
        end
    endfunction

    function [31:0] abs32;
        input [31:0] v;
        begin
            abs32 = v[31] ? (~v + 32'h00000001) : v;
        end
    endfunction

    // Byte-lane merge of a bus write into a stored word
    function [31:0] wmerge;
        input [31:0] old;
        input [31:0] nw;
        input [3:0]  sel;
        integer      b;
        begin
            wmerge = old;
            for (b = 0; b < 4; b = b + 1) begin
                if (sel[b]) begin
                    wmerge[8*b +: 8] = nw[8*b +: 8];
                end
            end
        end
    endfunction

    // Byte-lane merge for the 16-bit registers
    function [15:0] wmerge16;
        input [15:0] old;
        input [31:0] nw;
        input [3:0]  sel;
        begin
            wmerge16 = {sel[1] ? nw[15:8] : old[15:8],
                        sel[0] ? nw[7:0] : old[7:0]};
        end
    endfunction

    // Step one decimal digit, wrapping 9 to 0 and 0 to 9
    function [19:0] step_digit;
        input [19:0] v;
        input [2:0]  idx;
        input        up;
        reg   [3:0]  d;
        integer      k;
        begin
            step_digit = v;
            d = 4'h0;
            for (k = 0; k < 5; k = k + 1) begin
                if (idx == k[2:0]) begin
                    d = v[4*k +: 4];
                    if (up) begin
                        d = (d >= 4'h9) ? 4'h0 : d + 4'h1;
                    end else begin
                        d = (d == 4'h0) ? 4'h9 : d - 4'h1;
                    end
                    step_digit[4*k +: 4] = d;
                end
            end
        end
    endfunction

    ////////////////////////////////////////////////////////////////////
    // Key inputs

    psdl_key_debounce #(.DEBOUNCE_CYC(DEBOUNCE_CYC)) u_key_mode (
        .clk_i   (clk_i),
        .rst_i   (rst_i),
        .key_n_i (key_mode_n_i),
        .press_o (press_mode)
    );

    psdl_key_debounce #(.DEBOUNCE_CYC(DEBOUNCE_CYC)) u_key_up (
        .clk_i   (clk_i),
        .rst_i   (rst_i),
        .key_n_i (key_up_n_i),
        .press_o (press_up)
    );

    psdl_key_debounce #(.DEBOUNCE_CYC(DEBOUNCE_CYC)) u_key_down (
        .clk_i   (clk_i),
        .rst_i   (rst_i),
        .key_n_i (key_down_n_i),
        .press_o (press_down)
    );

    psdl_key_debounce #(.DEBOUNCE_CYC(DEBOUNCE_CYC)) u_key_data (
        .clk_i   (clk_i),
        .rst_i   (rst_i),
        .key_n_i (key_data_n_i),
        .press_o (press_data)
    );

    ////////////////////////////////////////////////////////////////////
    // Mode selection

    always @* begin
        mode_d = mode_q;
        case (mode_q)
            MD_INIT: begin
                if (init_done_i) begin
                    mode_d = MD_STATUS;
                end
            end
            MD_STATUS: begin
                if (press_mode) begin
                    mode_d = MD_PARAM;
                end
            end
            MD_PARAM: begin
                if (press_mode) begin
                    mode_d = MD_UTIL;
                end
            end
            MD_UTIL: begin
                if (press_mode) begin
                    mode_d = MD_MONITOR;
                end
            end
            MD_MONITOR: begin
                if (press_mode) begin
                    mode_d = MD_STATUS;
                end
            end
            default: begin
                mode_d = MD_INIT;
            end
        endcase
    end

    assign edit_mode = (mode_q == MD_PARAM) || (mode_q == MD_UTIL) ||
                       (mode_q == MD_MONITOR);
    assign in_alarm  = (drive_state_i == `PSDL_SC_ALARM);

    ////////////////////////////////////////////////////////////////////
    // Bus slave, one wait state per access

    assign wb_req = wb_cyc_i & wb_stb_i & ~wb_ack_o;
    // Write lands on the ack edge, while the request still stands
    assign wb_wr  = wb_cyc_i & wb_stb_i & wb_we_i & wb_ack_o;

    always @(posedge clk_i) begin
        if (rst_i) begin
            mode_q        <= MD_INIT;
            panel_mode_o  <= 4'h0;
            edit_value_o  <= `PSDL_RST_EDIT;
            edit_digit_o  <= 3'h0;
            value_shown_o <= 1'b0;
            alarm_clear_o <= 1'b0;
        end else begin
            mode_q        <= mode_d;
            panel_mode_o  <= mode_d[4:1];
            alarm_clear_o <= 1'b0;
            if (press_mode) begin
                value_shown_o <= 1'b0;
                edit_digit_o  <= 3'h0;
            end else if (press_data && mode_q == MD_STATUS) begin
                alarm_clear_o <= in_alarm;
            end else if (press_data && edit_mode) begin
                if (!value_shown_o) begin
                    value_shown_o <= 1'b1;
                end else begin
                    // Shift the active digit left, wrapping to the right
                    edit_digit_o <= (edit_digit_o == 3'h4) ? 3'h0 :
                                    edit_digit_o + 3'h1;
                end
            end
            // Bus write wins over a key press in the same cycle
            if (wb_wr && wb_adr_i == `PSDL_REG_EDIT) begin
                edit_value_o <= {(wb_sel_i[2] ? wb_dat_i[19:16] :
                                  edit_value_o[19:16]),
                                 wmerge16(edit_value_o[15:0],
                                          wb_dat_i, wb_sel_i)};
            end else if (press_up && edit_mode) begin
                edit_value_o <= step_digit(edit_value_o, edit_digit_o,
                                           1'b1);
            end else if (press_down && edit_mode) begin
                edit_value_o <= step_digit(edit_value_o, edit_digit_o,
                                           1'b0);
            end
        end
    end

    always @(posedge clk_i) begin
        if (rst_i) begin
            speed_th_q <= `PSDL_RST_SPEED_TH;
            pos_th_q   <= `PSDL_RST_POS_TH;
            rot_th_q   <= `PSDL_RST_ROT_TH;
            torq_lvl_q <= `PSDL_RST_TORQ_LVL;
            wb_ack_o   <= 1'b0;
            wb_dat_o   <= 32'h00000000;
        end else begin
            wb_ack_o <= wb_req;
            wb_dat_o <= 32'h00000000;
            if (wb_wr) begin
                case (wb_adr_i)
                    `PSDL_REG_SPEED_TH: begin
                        speed_th_q <= wmerge16(speed_th_q, wb_dat_i, wb_sel_i);
                    end
                    `PSDL_REG_POS_TH: begin
                        pos_th_q <= wmerge(pos_th_q, wb_dat_i, wb_sel_i);
                    end
                    `PSDL_REG_ROT_TH: begin
                        rot_th_q <= wmerge16(rot_th_q, wb_dat_i, wb_sel_i);
                    end
                    `PSDL_REG_TORQ_LVL: begin
                        torq_lvl_q <= wmerge16(torq_lvl_q, wb_dat_i, wb_sel_i);
                    end
                    default: begin
                    end
                endcase
            end else if (wb_req) begin
                case (wb_adr_i)
                    `PSDL_REG_STATUS: begin
                        wb_dat_o <= {12'h000, edit_digit_o, value_shown_o,
                                     1'b0, bit_seg_o, state_code_o,
                                     panel_mode_o};
                    end
                    `PSDL_REG_SPEED_TH: begin
                        wb_dat_o <= {16'h0000, speed_th_q};
                    end
                    `PSDL_REG_POS_TH: begin
                        wb_dat_o <= pos_th_q;
                    end
                    `PSDL_REG_ROT_TH: begin
                        wb_dat_o <= {16'h0000, rot_th_q};
                    end
                    `PSDL_REG_TORQ_LVL: begin
                        wb_dat_o <= {16'h0000, torq_lvl_q};
                    end
                    `PSDL_REG_EDIT: begin
                        wb_dat_o <= {12'h000, edit_value_o};
                    end
                    default: begin
                        wb_dat_o <= 32'h00000000;
                    end
                endcase
            end
        end
    end

    ////////////////////////////////////////////////////////////////////
    // Bit-data segments

    // Sign-extended so opposite-signed speeds cannot overflow
    assign speed_err    = {motor_speed_i[15], motor_speed_i} -
                          {speed_ref_i[15], speed_ref_i};
    assign speed_match  = abs17(speed_err) <= {1'b0, speed_th_q};
    assign pos_done     = abs32(pos_error_i) < pos_th_q;
    assign rot_seen     = abs16(motor_speed_i) > rot_th_q;
    assign speed_ref_hi = abs16(speed_ref_i) > rot_th_q;
    assign torq_ref_hi  = abs16(torque_ref_i) > torq_lvl_q;

    always @* begin
        seg_d = 7'h00;
        case (ctrl_mode_i)
            `PSDL_CM_POSITION: begin
                seg_d[0] = pos_done;
                seg_d[3] = ref_pulse_active_i;
                seg_d[4] = dev_clear_i;
            end
            `PSDL_CM_TORQUE: begin
                seg_d[0] = 1'b1;
                seg_d[3] = speed_ref_hi;
                seg_d[4] = torq_ref_hi;
            end
            default: begin
                seg_d[0] = speed_match;
                seg_d[3] = speed_ref_hi;
                seg_d[4] = torq_ref_hi;
            end
        endcase
        seg_d[1] = ~servo_on_i;
        seg_d[2] = ctrl_power_i;
        seg_d[5] = main_power_ok_i;
        seg_d[6] = rot_seen;
    end

    ////////////////////////////////////////////////////////////////////
    // Operation state code

    always @* begin
        if (drive_state_i > `PSDL_SC_ALM_NUM) begin
            code_d = `PSDL_SC_INIT_FAIL;
        end else if (in_alarm && alt_sel_q) begin
            // Alarm alternates with its number so both stay visible
            code_d = `PSDL_SC_ALM_NUM;
        end else begin
            code_d = drive_state_i;
        end
    end

    always @(posedge clk_i) begin
        if (rst_i) begin
            alt_cnt_q        <= 26'h0000000;
            alt_sel_q        <= 1'b0;
            bit_seg_o        <= 7'h00;
            state_code_o     <= `PSDL_SC_INIT_FAIL;
            state_code_pad_o <= 3'h0;
        end else begin
            if (!in_alarm) begin
                alt_cnt_q <= 26'h0000000;
                alt_sel_q <= 1'b0;
            end else if (alt_cnt_q >= ALT_CYC - 26'h0000001) begin
                alt_cnt_q <= 26'h0000000;
                alt_sel_q <= ~alt_sel_q;
            end else begin
                alt_cnt_q <= alt_cnt_q + 26'h0000001;
            end
            // Status digits only valid once in status display mode
            if (mode_q == MD_STATUS) begin
                bit_seg_o        <= seg_d;
                state_code_o     <= code_d;
                state_code_pad_o <= 3'h7;
            end else begin
                bit_seg_o        <= 7'h00;
                state_code_o     <= `PSDL_SC_INIT_FAIL;
                state_code_pad_o <= 3'h0;
            end
        end
    end

endmodule

//--- psdl_top_asserts.sv
// Concurrent checks on the ports of the panel status display logic
`timescale 1ns/10ps
module psdl_top_asserts (
    input wire       clk_i,
    input wire       rst_i,
    input wire       wb_cyc_i,
    input wire       wb_stb_i,
    input wire       wb_ack_o,
    input wire [1:0] ctrl_mode_i,
    input wire       servo_on_i,
    input wire       ctrl_power_i,
    input wire       main_power_ok_i,
    input wire [3:0] drive_state_i,
    input wire [3:0] panel_mode_o,
    input wire [6:0] bit_seg_o,
    input wire [2:0] state_code_pad_o,
    input wire [3:0] state_code_o,
    input wire       alarm_clear_o
);
    reg  st_q;
    wire st2;
    default clocking @(posedge clk_i); endclocking
    default disable iff (rst_i);
    // Status digits lag one cycle, so status must hold two samples
    always @(posedge clk_i) st_q <= !rst_i && panel_mode_o == 4'h1;
    assign st2 = st_q && panel_mode_o == 4'h1;
    ////////////////////////////////////////
    a_ack_pulse:
        assert property (wb_ack_o |=> !wb_ack_o)
        else $error("ack held longer than one cycle");
    a_ack_answer:
        assert property (wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o)
        else $error("bus request not acknowledged next cycle");
    a_mode_next:
        assert property ($changed(panel_mode_o) && $past(panel_mode_o) != 4'h0
            |-> panel_mode_o == {$past(panel_mode_o[2:0]),
                                 $past(panel_mode_o[3])})
        else $error("mode did not step to the next basic mode");
    a_init_status:
        assert property ($changed(panel_mode_o) && $past(panel_mode_o) == 4'h0
            |-> panel_mode_o == 4'h1)
        else $error("mode left init other than to status");
    a_seg1_torque:
        assert property (st2 && $past(ctrl_mode_i) == 2'h2 |-> bit_seg_o[0])
        else $error("segment 1 dark in torque mode");
    a_seg2_servo:
        assert property (st2 |-> bit_seg_o[1] == !$past(servo_on_i))
        else $error("segment 2 does not follow servo off");
    a_seg_power:
        assert property (st2 |-> bit_seg_o[2] == $past(ctrl_power_i)
            && bit_seg_o[5] == $past(main_power_ok_i))
        else $error("power segments wrong");
    a_pad_status:
        assert property (st2 |-> state_code_pad_o == 3'h7)
        else $error("code digits inactive in status mode");
    a_code_follow:
        assert property (st2 && $past(drive_state_i) != 4'h5
            |-> state_code_o == ($past(drive_state_i) > 4'hA ? 4'h0
                                 : $past(drive_state_i)))
        else $error("state code does not follow drive state");
    a_clear_pulse:
        assert property (alarm_clear_o |=> !alarm_clear_o)
        else $error("alarm clear longer than one cycle");
    a_clear_alarm:
        assert property (alarm_clear_o |-> $past(drive_state_i) == 4'h5)
        else $error("alarm clear outside alarm state");
    c_bus: cover property (wb_ack_o);
    c_monitor: cover property (panel_mode_o == 4'h8);
    c_alarm_num: cover property (st2 && state_code_o == 4'hA);
    c_clear: cover property (alarm_clear_o);
endmodule

bind psdl_top psdl_top_asserts chk_u (.clk_i(clk_i), .rst_i(rst_i),
    .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i), .wb_ack_o(wb_ack_o),
    .ctrl_mode_i(ctrl_mode_i), .servo_on_i(servo_on_i),
    .ctrl_power_i(ctrl_power_i), .main_power_ok_i(main_power_ok_i),
    .drive_state_i(drive_state_i), .panel_mode_o(panel_mode_o),
    .bit_seg_o(bit_seg_o), .state_code_pad_o(state_code_pad_o),
    .state_code_o(state_code_o), .alarm_clear_o(alarm_clear_o));

//--- psdl_key_panel.sv
// Operator model pressing one key with contact bounce
`timescale 1ns/10ps
module psdl_key_panel (
    input  wire       clk_i,
    input  wire       go_i,
    input  wire [1:0] key_sel_i,
    output reg  [3:0] key_n_o,
    output reg        busy_o
);
    reg  [1:0] sel_q = 2'h0;
    int        cnt = 0;
    initial busy_o = 1'b0;
    always @(posedge clk_i) begin
        if (go_i && !busy_o) begin
            busy_o <= 1'b1;
            sel_q  <= key_sel_i;
            cnt    <= 0;
        end else if (busy_o) begin
            cnt    <= cnt + 1;
            busy_o <= cnt < 30;
        end
    end
    // Bounce at cnt 1; a released key returns to its pull-up level
    always @* begin
        key_n_o = 4'hF;
        if (busy_o && cnt != 1 && cnt < 14) key_n_o[sel_q] = 1'b0;
    end
endmodule

//--- panel_status_display_logic_bench.sv
// Self-checking bench for the panel status display logic
`timescale 1ns/10ps
module panel_status_display_logic_bench;
reg         clk_i = 1'b0;
reg         rst_i = 1'b1;
reg         cyc = 1'b0, stb = 1'b0, we = 1'b0, init_done = 1'b0;
reg         servo_on = 1'b0, ctrl_power = 1'b0, main_ok = 1'b0;
reg         ref_pulse = 1'b0, dev_clear = 1'b0, kgo = 1'b0;
reg  [1:0]  ctrl_mode = 2'h0, ksel = 2'h0;
reg  [7:0]  adr = 8'h00;
reg  [31:0] dat = 32'h00000000, p_err = 32'h00000000, q;
reg  [15:0] m_speed = 16'h0000, s_ref = 16'h0000, t_ref = 16'h0000;
reg  [3:0]  d_state = 4'h0;
reg  [31:0] seed = 32'h00016FFB;
reg  [7:0]  ra[5] = '{8'h04, 8'h08, 8'h0C, 8'h10, 8'h40};
wire [31:0] rdat;
wire        ack, shown_o, clr_o, kbusy;
wire [3:0]  mode_o, code_o, key_n;
wire [6:0]  seg_o;
wire [2:0]  pad_o, digit_o;
wire [19:0] edit_o;
int         bad_count = 0, n_checks = 0, clr_cnt = 0;
int         sth = 10, pth = 10, rth = 20, tlv = 10;
int         cm, ms, sr, tr, pe, ds, i, md = -1, cur = 0, shn = 0;
int         rv[5] = '{10, 10, 20, 10, 0};
int         dg[5] = '{0, 0, 0, 0, 0};
int         ks[10] = '{0, 3, 1, 2, 2, 3, 1, 0, 0, 0};
bit         so, cp, mp, rp, dc, seen5, seen_a;

always #4 clk_i = ~clk_i;

psdl_top #(.DEBOUNCE_CYC(21'h000004), .ALT_CYC(26'h0000008)) dut_u (
    .clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(cyc), .wb_stb_i(stb),
    .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(4'hF), .wb_dat_i(dat),
    .wb_dat_o(rdat), .wb_ack_o(ack), .key_mode_n_i(key_n[0]),
    .key_up_n_i(key_n[1]), .key_down_n_i(key_n[2]),
    .key_data_n_i(key_n[3]), .init_done_i(init_done),
    .ctrl_mode_i(ctrl_mode), .servo_on_i(servo_on),
    .ctrl_power_i(ctrl_power), .main_power_ok_i(main_ok),
    .ref_pulse_active_i(ref_pulse), .dev_clear_i(dev_clear),
    .motor_speed_i(m_speed), .speed_ref_i(s_ref), .torque_ref_i(t_ref),
    .pos_error_i(p_err), .drive_state_i(d_state), .panel_mode_o(mode_o),
    .bit_seg_o(seg_o), .state_code_pad_o(pad_o), .state_code_o(code_o),
    .edit_value_o(edit_o), .edit_digit_o(digit_o),
    .value_shown_o(shown_o), .alarm_clear_o(clr_o));
psdl_key_panel key_u (.clk_i(clk_i), .go_i(kgo), .key_sel_i(ksel),
    .key_n_o(key_n), .busy_o(kbusy));

always @(posedge clk_i) begin
    if (clr_o === 1'b1) clr_cnt++;
    if (mode_o === 4'h1 && code_o === 4'h5) seen5 = 1'b1;
    if (mode_o === 4'h1 && code_o === 4'hA) seen_a = 1'b1;
end
////////////////////////////////////////
function automatic [31:0] lfsr(input [31:0] s);
    lfsr = {1'b0, s[31:1]} ^ (s[0] ? 32'h80200003 : 32'h00000000);
endfunction
function automatic int ab(input int v);
    ab = v < 0 ? -v : v;
endfunction
function automatic [6:0] exp_seg();
    bit p;
    p = cm == 1;
    exp_seg[0] = cm == 2 ? 1'b1 : p ? ab(pe) < pth : ab(ms - sr) <= sth;
    exp_seg[1] = !so;
    exp_seg[2] = cp;
    exp_seg[3] = p ? rp : ab(sr) > rth;
    exp_seg[4] = p ? dc : ab(tr) > tlv;
    exp_seg[5] = mp;
    exp_seg[6] = ab(ms) > rth;
endfunction
task chk(input string nm, input [31:0] e, input [31:0] g);
    begin
        n_checks++;
        if (g !== e) begin
            $display("Error %s expected %h seen %h", nm, e, g);
            bad_count++;
        end
    end
endtask
task wrap_up;
    begin
        if (bad_count == 0 && n_checks > 0) $display("TEST PASSED");
        else $display("TEST FAILED");
        $finish;
    end
endtask
task wb(input [7:0] a, input w, input [31:0] d);
    int t;
    begin
        @(posedge clk_i);
        {cyc, stb, we, adr, dat} <= {2'b11, w, a, d};
        @(posedge clk_i);
        for (t = 0; ack !== 1'b1 && t < 50; t++) @(posedge clk_i);
        q = rdat;
        {cyc, stb} <= 2'b00;
        chk("ack", 1, t < 50);
    end
endtask
task sample;
    begin
        seed = lfsr(seed);
        cm = seed[1:0];
        {so, cp, mp, rp, dc} = seed[6:2];
        ms = int'(seed[12:7]) - 32;
        sr = int'(seed[18:13]) - 32;
        tr = int'(seed[23:19]) - 16;
        pe = int'(seed[28:24]) - 16;
        ds = seed[31:28] == 4'h5 ? 6 : seed[31:28];
        {servo_on, ctrl_power, main_ok, ref_pulse, dev_clear, ctrl_mode}
            <= seed[6:0];
        {m_speed, s_ref, t_ref} <= {ms[15:0], sr[15:0], tr[15:0]};
        p_err <= pe;
        d_state <= ds[3:0];
        repeat (3) @(posedge clk_i);
        chk("segments", exp_seg(), seg_o);
        chk("segments", exp_seg(), seg_o);
        chk("code", ds > 10 ? 0 : ds, code_o);
        chk("pad", 7, pad_o);
    end
endtask
task press(input int k);
    int t;
    begin
        @(posedge clk_i);
        {kgo, ksel} <= {1'b1, k[1:0]};
        @(posedge clk_i);
        kgo <= 1'b0;
        @(posedge clk_i);
        for (t = 0; kbusy !== 1'b0 && t < 100; t++) @(posedge clk_i);
        chk("key", 1, t < 100);
        if (md >= 0) case (k)
            0: begin
                md = (md + 1) % 4;
                shn = 0;
                cur = 0;
            end
            1, 2: if (md == 1) dg[cur] = (dg[cur] + (k == 1 ? 1 : 9)) % 10;
            3: if (md == 1) begin
                cur = shn ? (cur + 1) % 5 : cur;
                shn = 1;
            end
        endcase
        chk("mode", md < 0 ? 0 : 1 << md, mode_o);
        chk("edit", {dg[4][3:0], dg[3][3:0], dg[2][3:0], dg[1][3:0],
            dg[0][3:0]}, edit_o);
        chk("cursor", {shn[0], cur[2:0]}, {shown_o, digit_o});
    end
endtask
////////////////////////////////////////
initial begin
    repeat (20) @(posedge clk_i);
    rst_i <= 1'b0;
    press(0);
    init_done <= 1'b1;
    md = 0;
    repeat (4) @(posedge clk_i);
    chk("mode", 1, mode_o);
    for (i = 0; i < 5; i++) begin
        wb(ra[i], 1'b0, 32'h00000000);
        chk("register", rv[i], q);
    end
    repeat (40) sample;
    for (i = 0; i < 4; i++) begin
        rv[i] = i + 3;
        wb(ra[i], 1'b1, rv[i]);
    end
    sth = rv[0];
    pth = rv[1];
    rth = rv[2];
    tlv = rv[3];
    wb(8'h00, 1'b1, 32'hFFFFFFFF);
    wb(8'h00, 1'b0, 32'h00000000);
    chk("status", 1, q[3:0]);
    wb(ra[2], 1'b0, 32'h00000000);
    chk("register", 5, q);
    repeat (40) sample;
    {seen5, seen_a} = 2'b00;
    d_state <= 4'h5;
    press(3);
    chk("clear", 1, clr_cnt);
    chk("alarm", 3, {seen5, seen_a});
    d_state <= 4'h0;
    foreach (ks[j]) press(ks[j]);
    chk("clear", 1, clr_cnt);
    wrap_up;
end
initial begin
    repeat (40000) @(posedge clk_i);
    bad_count++;
    wrap_up;
end
endmodule
